// *** hw/psdi_map.svh ***
`ifndef PSDI_MAP_SVH
`define PSDI_MAP_SVH
`define PSDI_A_CAP      8'h00
`define PSDI_A_CTRL     8'h04
`define PSDI_A_STATUS   8'h08
`define PSDI_A_CTX_IDX  8'h0c
`define PSDI_A_CTX_DATA 8'h10
`define PSDI_A_ST_IDX   8'h14
`define PSDI_A_ST_DATA  8'h18
`define PSDI_A_ST_CMP   8'h1c
`define PSDI_A_ST_XCHG  8'h20
`define PSDI_CAP_VAL    32'h0000_0001
`define PSDI_CTRL_RST   1'h1
`define PSDI_CX_AIE     0
`define PSDI_CX_DIE     1
`define PSDI_CX_ERR     2
`define PSDI_CX_PTS     7:4
`define PSDI_CX_BASE    15:8
`define PSDI_PTS_BIAS   5'h05
`define PSDI_ST_CNT     15:0
`define PSDI_ST_PIF     31
`define PSDI_RC_OK      1'h0
`define PSDI_RC_INV     1'h1
`define PSDI_OKAY       2'h0
`define PSDI_SLVERR     2'h2
`endif

// *** hw/psdi_pkg.sv ***
package psdi_pkg;
`include "psdi_map.svh"
  typedef enum logic [2:0] {
    S_IDLE, S_CTX, S_RMW, S_INVAL, S_RESP, S_SW_CTX, S_SW_ST
  } psdi_state_e;
  typedef enum logic [2:0] {
    OP_NONE, OP_CTX_RD, OP_CTX_WR, OP_ST_RD, OP_ST_WR, OP_XCHG
  } psdi_op_e;
  function automatic logic psdi_mapped(input logic [7:0] a);
    return (a <= `PSDI_A_ST_XCHG) && (a[1:0] == 2'h0);
  endfunction
endpackage

// *** hw/psdi_mem.sv ***
`timescale 1ns/1ns
module psdi_mem #(
  parameter int AW = 4
) (
  input  wire logic          aclk,   // clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] addr,   // word address
  input  wire logic [31:0]   wdata,  // write word
  output logic      [31:0]   rdata   // registered read word
);
  logic [31:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are undefined until software loads them
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // psdi_mem

// *** hw/psdi_axil.sv ***
`timescale 1ns/1ns
module psdi_axil
  import psdi_pkg::*;
(
  input  wire logic        aclk,       // clock
  input  wire logic        aresetn,    // sync reset, low
  input  wire logic [7:0]  s_awaddr,   // write address
  input  wire logic        s_awvalid,  // write address valid
  output logic             s_awready,  // write address ready
  input  wire logic [31:0] s_wdata,    // write data
  input  wire logic [3:0]  s_wstrb,    // byte enables
  input  wire logic        s_wvalid,   // write data valid
  output logic             s_wready,   // write data ready
  output logic [1:0]       s_bresp,    // write response
  output logic             s_bvalid,   // write response valid
  input  wire logic        s_bready,   // write response ready
  input  wire logic [7:0]  s_araddr,   // read address
  input  wire logic        s_arvalid,  // read address valid
  output logic             s_arready,  // read address ready
  output logic [31:0]      s_rdata,    // read data
  output logic [1:0]       s_rresp,    // read response
  output logic             s_rvalid,   // read data valid
  input  wire logic        s_rready,   // read data ready
  output logic             wr_en,      // register write pulse
  output logic [7:0]       wr_addr,    // register write address
  output logic [31:0]      wr_data,    // register write word
  input  wire logic        wr_ready,   // core can take a write
  output logic [7:0]       rd_addr,    // register read address
  input  wire logic [31:0] rd_data     // register read word
);
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_full;
    logic        w_full;
    logic        bvalid;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [7:0]  awaddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } psdi_axil_s;

  localparam psdi_axil_s RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  psdi_axil_s r_r, r_nxt;
  logic       ok;

  assign wr_addr = r_r.awaddr;
  assign wr_data = r_r.wdata;
  assign rd_addr = s_araddr;

  always_comb
  begin
    r_nxt = r_r;
    wr_en = 1'b0;
    ok    = 1'b0;
    if (s_awvalid && r_r.awready)
    begin
      r_nxt.aw_full = 1'b1;
      r_nxt.awaddr  = s_awaddr;
    end
    if (s_wvalid && r_r.wready)
    begin
      r_nxt.w_full = 1'b1;
      r_nxt.wdata  = s_wdata;
      r_nxt.wstrb  = s_wstrb;
    end
    if (r_r.bvalid && s_bready)
    begin
      r_nxt.bvalid = 1'b0;
    end
    // partial writes are refused: every register is one indivisible word
    if (r_r.aw_full && r_r.w_full && !r_r.bvalid && wr_ready)
    begin
      ok            = psdi_mapped(r_r.awaddr) && (r_r.wstrb == 4'hf);
      wr_en         = ok;
      r_nxt.bresp   = ok ? `PSDI_OKAY : `PSDI_SLVERR;
      r_nxt.bvalid  = 1'b1;
      r_nxt.aw_full = 1'b0;
      r_nxt.w_full  = 1'b0;
    end
    r_nxt.awready = !r_nxt.aw_full;
    r_nxt.wready  = !r_nxt.w_full;
    if (s_arvalid && r_r.arready)
    begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid  = 1'b1;
      r_nxt.rdata   = rd_data;
      r_nxt.rresp   = psdi_mapped(s_araddr) ? `PSDI_OKAY : `PSDI_SLVERR;
    end
    if (r_r.rvalid && s_rready)
    begin
      r_nxt.rvalid  = 1'b0;
      r_nxt.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_r <= RST;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign s_awready = r_r.awready;
  assign s_wready  = r_r.wready;
  assign s_bvalid  = r_r.bvalid;
  assign s_bresp   = r_r.bresp;
  assign s_arready = r_r.arready;
  assign s_rvalid  = r_r.rvalid;
  assign s_rdata   = r_r.rdata;
  assign s_rresp   = r_r.rresp;
endmodule // psdi_axil

// *** hw/psdi_core.sv ***
// Behaviour
// - success response carries code zero
// - failures answer with code one
// - state table base and size from context
// - address-space id indexes the state table
// - nonzero count means space is active
// - capability bit reports deferred invalidation support
// - source id selects the context entry
// - context faults skip update, answer at once
// - state entry updated as locked read-modify-write
// - active type increments, clears pending flag
// - inactive type decrements, keeps pending flag
// - active with pending flag: invalidate, sync set
// - otherwise synchronize flag is zero
// - success response carries computed sync flag
// - messages keep posted ordering
// - requests processed strictly in arrival order
// - response echoes source, id and type
// - own invalidation finishes before the response
`timescale 1ns/1ns
`include "psdi_map.svh"
module psdi_core
  import psdi_pkg::*;
#(
  parameter int CAW  = 4,   // context index bits
  parameter int SAW  = 8,   // state table index bits
  parameter int SIDW = 16,  // source id bits
  parameter int PW   = 20   // address-space id bits
) (
  input  wire logic            aclk,          // clock
  input  wire logic            aresetn,       // sync reset, low
  input  wire logic [7:0]      s_awaddr,      // axi write address
  input  wire logic            s_awvalid,     // axi write address valid
  output logic                 s_awready,     // axi write address ready
  input  wire logic [31:0]     s_wdata,       // axi write data
  input  wire logic [3:0]      s_wstrb,       // axi byte enables
  input  wire logic            s_wvalid,      // axi write data valid
  output logic                 s_wready,      // axi write data ready
  output logic [1:0]           s_bresp,       // axi write response
  output logic                 s_bvalid,      // axi write response valid
  input  wire logic            s_bready,      // axi write response ready
  input  wire logic [7:0]      s_araddr,      // axi read address
  input  wire logic            s_arvalid,     // axi read address valid
  output logic                 s_arready,     // axi read address ready
  output logic [31:0]          s_rdata,       // axi read data
  output logic [1:0]           s_rresp,       // axi read response
  output logic                 s_rvalid,      // axi read data valid
  input  wire logic            s_rready,      // axi read data ready
  input  wire logic            req_valid,     // state-update request valid
  output logic                 req_ready,     // request taken when both high
  input  wire logic [SIDW-1:0] req_source_id, // requester id
  input  wire logic [PW-1:0]   req_pasid,     // address-space id
  input  wire logic            req_type,      // 1 active, 0 inactive
  output logic                 rsp_valid,     // response valid
  input  wire logic            rsp_ready,     // response taken when both high
  output logic [SIDW-1:0]      rsp_target_id, // echoed requester id
  output logic [PW-1:0]        rsp_pasid,     // echoed address-space id
  output logic                 rsp_type,      // echoed type
  output logic                 rsp_code,      // 0 success, 1 invalid
  output logic                 rsp_sync,      // synchronize flag
  output logic                 inval_valid,   // translation cache flush request
  output logic [PW-1:0]        inval_pasid,   // space to flush, non-globals only
  input  wire logic            inval_done     // flush finished
);
  typedef struct packed {
    psdi_state_e     st;
    psdi_op_e        op;
    logic            req_ready;
    logic            rsp_valid;
    logic            inv_valid;
    logic            code;
    logic            sync;
    logic            typ;
    logic            ctrl_en;
    logic            xchg_ok;
    logic [SIDW-1:0] src;
    logic [PW-1:0]   pasid;
    logic [SAW-1:0]  sidx;
    logic [31:0]     sw_idx;
    logic [31:0]     sw_data;
    logic [31:0]     sw_cmp;
    logic [31:0]     ctx_sh;
    logic [31:0]     st_sh;
    logic [15:0]     err_cnt;
  } psdi_core_s;

  localparam psdi_core_s RST = '{st: S_IDLE, op: OP_NONE, ctrl_en: `PSDI_CTRL_RST, default: '0};

  psdi_core_s      r_r, r_nxt;
  logic            wr_en, wr_ready;
  logic [7:0]      wr_addr, rd_addr;
  logic [31:0]     wr_data, rd_data;
  logic            cm_we, sm_we;
  logic [CAW-1:0]  cm_addr;
  logic [SAW-1:0]  sm_addr;
  logic [31:0]     cm_wdata, cm_rdata, sm_wdata, sm_rdata;
  logic [PW:0]     sum;
  logic [4:0]      lim;
  logic            bad;

  psdi_axil u_axil (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_ready  (wr_ready),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  psdi_mem #(.AW(CAW)) u_ctx (
    .aclk  (aclk),
    .we    (cm_we),
    .addr  (cm_addr),
    .wdata (cm_wdata),
    .rdata (cm_rdata)
  );

  psdi_mem #(.AW(SAW)) u_state (
    .aclk  (aclk),
    .we    (sm_we),
    .addr  (sm_addr),
    .wdata (sm_wdata),
    .rdata (sm_rdata)
  );

  // one software access at a time; the slave stalls further writes meanwhile, reads still answer
  assign wr_ready = (r_r.op == OP_NONE);

  always_comb
  begin
    r_nxt    = r_r;
    cm_we    = 1'b0;
    cm_addr  = r_r.sw_idx[CAW-1:0];
    cm_wdata = r_r.sw_data;
    sm_we    = 1'b0;
    sm_addr  = r_r.sw_idx[SAW-1:0];
    sm_wdata = r_r.sw_data;
    lim      = {1'b0, cm_rdata[`PSDI_CX_PTS]} + `PSDI_PTS_BIAS;
    sum      = (PW+1)'(cm_rdata[`PSDI_CX_BASE]) + (PW+1)'(r_r.pasid);
    bad      = cm_rdata[`PSDI_CX_ERR] || !cm_rdata[`PSDI_CX_AIE]
               || !cm_rdata[`PSDI_CX_DIE]
               || ((r_r.src >> CAW) != '0)
               || ((r_r.pasid >> lim) != '0)
               || ((sum >> SAW) != '0);
    if (wr_en)
    begin
      if (wr_addr == `PSDI_A_CTRL)
      begin
        r_nxt.ctrl_en = wr_data[0];
      end
      else if (wr_addr == `PSDI_A_CTX_IDX)
      begin
        r_nxt.sw_idx = wr_data;
        r_nxt.op     = OP_CTX_RD;
      end
      else if (wr_addr == `PSDI_A_CTX_DATA)
      begin
        r_nxt.sw_data = wr_data;
        r_nxt.ctx_sh  = wr_data;
        r_nxt.op      = OP_CTX_WR;
      end
      else if (wr_addr == `PSDI_A_ST_IDX)
      begin
        r_nxt.sw_idx = wr_data;
        r_nxt.op     = OP_ST_RD;
      end
      else if (wr_addr == `PSDI_A_ST_DATA)
      begin
        r_nxt.sw_data = wr_data;
        r_nxt.st_sh   = wr_data;
        r_nxt.op      = OP_ST_WR;
      end
      else if (wr_addr == `PSDI_A_ST_CMP)
      begin
        r_nxt.sw_cmp = wr_data;
      end
      else if (wr_addr == `PSDI_A_ST_XCHG)
      begin
        r_nxt.sw_data = wr_data;
        r_nxt.op      = OP_XCHG;
      end
    end
    case (r_r.st)
      S_IDLE:
      begin
        r_nxt.req_ready = 1'b0;
        // requests are served one at a time, in arrival order
        if (req_valid && r_r.req_ready)
        begin
          r_nxt.src   = req_source_id;
          r_nxt.pasid = req_pasid;
          r_nxt.typ   = req_type;
          cm_addr     = req_source_id[CAW-1:0];
          r_nxt.st    = S_CTX;
        end
        else if (r_r.op == OP_CTX_WR)
        begin
          cm_we    = 1'b1;
          r_nxt.op = OP_NONE;
        end
        else if (r_r.op == OP_CTX_RD)
        begin
          r_nxt.st = S_SW_CTX;
        end
        else if (r_r.op == OP_ST_WR)
        begin
          sm_we    = 1'b1;
          r_nxt.op = OP_NONE;
        end
        else if (r_r.op != OP_NONE)
        begin
          r_nxt.st = S_SW_ST;
        end
        else
        begin
          r_nxt.req_ready = r_r.ctrl_en;
        end
      end
      S_CTX:
      begin
        if (bad)
        begin
          r_nxt.code      = `PSDI_RC_INV;
          r_nxt.sync      = 1'b0;
          r_nxt.rsp_valid = 1'b1;
          r_nxt.st        = S_RESP;
        end
        else
        begin
          r_nxt.sidx = sum[SAW-1:0];
          sm_addr    = sum[SAW-1:0];
          r_nxt.st   = S_RMW;
        end
      end
      S_RMW:
      begin
        // the state memory is owned by this walk from read to write,
        // so software cannot slip a change in between
        sm_addr  = r_r.sidx;
        sm_we    = 1'b1;
        sm_wdata = sm_rdata;
        if (r_r.typ)
        begin
          sm_wdata[`PSDI_ST_CNT] = sm_rdata[`PSDI_ST_CNT] + 16'h0001;
          sm_wdata[`PSDI_ST_PIF] = 1'b0;
        end
        else
        begin
          sm_wdata[`PSDI_ST_CNT] = sm_rdata[`PSDI_ST_CNT] - 16'h0001;
        end
        r_nxt.code = `PSDI_RC_OK;
        r_nxt.sync = r_r.typ && sm_rdata[`PSDI_ST_PIF];
        if (r_r.typ && sm_rdata[`PSDI_ST_PIF])
        begin
          r_nxt.inv_valid = 1'b1;
          r_nxt.st        = S_INVAL;
        end
        else
        begin
          r_nxt.rsp_valid = 1'b1;
          r_nxt.st        = S_RESP;
        end
      end
      S_INVAL:
      begin
        if (inval_done)
        begin
          r_nxt.inv_valid = 1'b0;
          r_nxt.rsp_valid = 1'b1;
          r_nxt.st        = S_RESP;
        end
      end
      S_RESP:
      begin
        if (rsp_ready)
        begin
          r_nxt.rsp_valid = 1'b0;
          r_nxt.err_cnt   = r_r.err_cnt + 16'(r_r.code);
          r_nxt.st        = S_IDLE;
        end
      end
      S_SW_CTX:
      begin
        r_nxt.ctx_sh = cm_rdata;
        r_nxt.op     = OP_NONE;
        r_nxt.st     = S_IDLE;
      end
      S_SW_ST:
      begin
        r_nxt.st_sh = sm_rdata;
        if (r_r.op == OP_XCHG)
        begin
          r_nxt.xchg_ok = (sm_rdata == r_r.sw_cmp);
          if (sm_rdata == r_r.sw_cmp)
          begin
            sm_we       = 1'b1;
            r_nxt.st_sh = r_r.sw_data;
          end
        end
        r_nxt.op = OP_NONE;
        r_nxt.st = S_IDLE;
      end
      default:
      begin
        r_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_r <= RST;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (rd_addr == `PSDI_A_CAP)
    begin
      rd_data = `PSDI_CAP_VAL;
    end
    else if (rd_addr == `PSDI_A_CTRL)
    begin
      rd_data = {31'h0, r_r.ctrl_en};
    end
    else if (rd_addr == `PSDI_A_STATUS)
    begin
      rd_data = {r_r.err_cnt, 13'h0, r_r.xchg_ok, r_r.op != OP_NONE, r_r.st != S_IDLE};
    end
    else if (rd_addr == `PSDI_A_CTX_IDX || rd_addr == `PSDI_A_ST_IDX)
    begin
      rd_data = r_r.sw_idx;
    end
    else if (rd_addr == `PSDI_A_CTX_DATA)
    begin
      rd_data = r_r.ctx_sh;
    end
    else if (rd_addr == `PSDI_A_ST_DATA)
    begin
      rd_data = r_r.st_sh;
    end
    else if (rd_addr == `PSDI_A_ST_CMP)
    begin
      rd_data = r_r.sw_cmp;
    end
  end

  assign req_ready     = r_r.req_ready;
  assign rsp_valid     = r_r.rsp_valid;
  assign rsp_target_id = r_r.src;
  assign rsp_pasid     = r_r.pasid;
  assign rsp_type      = r_r.typ;
  assign rsp_code      = r_r.code;
  assign rsp_sync      = r_r.sync;
  assign inval_valid   = r_r.inv_valid;
  assign inval_pasid   = r_r.pasid;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sync_only_act: assert property (rsp_valid |-> !(rsp_sync && (rsp_code || !rsp_type)))
    else $error("sync flag set on inactive or failed response");
  a_inval_then_rsp: assert property (inval_valid && inval_done |=> rsp_valid && rsp_sync)
    else $error("response did not follow finished invalidation");
  a_rsp_after_flush: assert property ($rose(rsp_valid) && rsp_sync |-> $past(inval_done))
    else $error("sync response sent before invalidation finished");
  a_bad_ctx_fast: assert property (r_r.st == S_CTX && bad |=> rsp_valid && rsp_code)
    else $error("context fault not answered at once with invalid code");
  a_rmw_locked: assert property (r_r.st == S_CTX && !bad |=> r_r.st == S_RMW ##1 !sm_we)
    else $error("state update not a single read-modify-write");
  a_inc_clear: assert property (r_r.st == S_RMW && r_r.typ |-> !sm_wdata[`PSDI_ST_PIF]
      && sm_wdata[`PSDI_ST_CNT] == sm_rdata[`PSDI_ST_CNT] + 16'h0001)
    else $error("active update did not increment and clear");
  a_dec_keep: assert property (r_r.st == S_RMW && !r_r.typ |-> sm_wdata[`PSDI_ST_PIF]
      == sm_rdata[`PSDI_ST_PIF] && sm_wdata[`PSDI_ST_CNT] == sm_rdata[`PSDI_ST_CNT] - 16'h0001)
    else $error("inactive update did not decrement or lost flag");
  a_ok_code: assert property (r_r.st == S_RMW |=> rsp_code == `PSDI_RC_OK)
    else $error("successful update reported a failure code");
  a_one_at_time: assert property (req_ready |-> r_r.st == S_IDLE && !rsp_valid && !inval_valid)
    else $error("new request accepted while one in flight");
  a_echo_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_pasid)
      && $stable(rsp_target_id) && $stable(rsp_sync))
    else $error("response changed before it was taken");
endmodule // psdi_core

// *** testbench/psdi_ep_model.sv ***
`timescale 1ns/1ns
module psdi_ep_model #(
  parameter int SIDW = 16,
  parameter int PW   = 20
) (
  input  wire logic          aclk,          // clock
  output logic               req_valid,     // request valid
  input  wire logic          req_ready,     // request taken
  output logic [SIDW-1:0]    req_source_id, // requester id
  output logic [PW-1:0]      req_pasid,     // space id
  output logic               req_type,      // 1 active
  input  wire logic          rsp_valid,     // response valid
  output logic               rsp_ready,     // response taken
  input  wire logic          rsp_code,      // 1 invalid
  input  wire logic          rsp_sync,      // synchronize flag
  input  wire logic          inval_valid,   // flush asked
  input  wire logic [PW-1:0] inval_pasid,   // space to flush
  output logic               inval_done     // flush finished
);
  int            dly = 0;
  int            cnt = 0;
  int            n_inv = 0;
  int            n_kill = 0;
  int            n_flush = 0;
  logic [PW-1:0] last_p = '0;
  logic          early = 1'b0;
  initial
  begin
    req_valid = 1'b0;
    req_source_id = '0;
    req_pasid = '0;
    req_type = 1'b0;
    rsp_ready = 1'b0;
    inval_done = 1'b0;
  end
  // flush stand-in: one-cycle done after dly waiting cycles
  always @(posedge aclk)
  begin
    inval_done <= 1'b0;
    // unknown before the first reset edge must not look like a flush request
    if (inval_valid !== 1'b1)
      cnt <= 0;
    else if (!inval_done && cnt < dly)
      cnt <= cnt + 1;
    else if (!inval_done)
    begin
      inval_done <= 1'b1;
      n_inv <= n_inv + 1;
      last_p <= inval_pasid;
    end
    if (rsp_valid && inval_valid)
      early <= 1'b1;
  end
  task automatic send(input logic [SIDW-1:0] s, input logic [PW-1:0] p, input logic t);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_source_id <= s;
    req_pasid <= p;
    req_type <= t;
    rsp_ready <= 1'b1;
    @(posedge aclk);
    while (!req_ready)
      @(posedge aclk);
    req_valid <= 1'b0;
    // released space id must not keep a usable value
    req_pasid <= ~p;
    // one request in flight, completed only on its response
    while (!rsp_valid)
      @(posedge aclk);
    rsp_ready <= 1'b0;
    if (rsp_code !== 1'b0)
      n_kill++;
    else if (req_type && rsp_sync)
      n_flush++;
  endtask
endmodule // psdi_ep_model

// *** testbench/psdi_core_tb_top.sv ***
`timescale 1ns/1ns
`include "psdi_map.svh"
module psdi_core_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        req_valid, req_ready, req_type, rsp_valid, rsp_ready;
  logic        rsp_type, rsp_code, rsp_sync, inval_valid, inval_done;
  logic [15:0] req_sid, rsp_tid;
  logic [19:0] req_pasid, rsp_pasid, inval_pasid;
  int          n_errors = 0;
  int          samples_checked = 0;
  psdi_core i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .req_valid(req_valid),
    .req_ready(req_ready), .req_source_id(req_sid), .req_pasid(req_pasid),
    .req_type(req_type), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_target_id(rsp_tid), .rsp_pasid(rsp_pasid), .rsp_type(rsp_type),
    .rsp_code(rsp_code), .rsp_sync(rsp_sync), .inval_valid(inval_valid),
    .inval_pasid(inval_pasid), .inval_done(inval_done)
  );
  psdi_ep_model i_ep (
    .aclk(aclk), .req_valid(req_valid), .req_ready(req_ready), .req_source_id(req_sid),
    .req_pasid(req_pasid), .req_type(req_type), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .inval_valid(inval_valid), .inval_pasid(inval_pasid),
    .inval_done(inval_done), .rsp_code(rsp_code), .rsp_sync(rsp_sync)
  );
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awready)
      begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready)
      begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (!bvalid)
      @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready)
      @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid)
      @(posedge aclk);
    v = rdata;
    q = rresp;
    rready <= 1'b0;
  endtask
  // shadow refresh is not instant, so poll the pending bit first
  task automatic sw_wait(output logic [31:0] s);
    logic [1:0] q;
    do
      axr(`PSDI_A_STATUS, s, q);
    while (s[1] !== 1'b0);
  endtask
  task automatic rd_st(input logic [7:0] i, output logic [31:0] v);
    logic [31:0] s;
    logic [1:0]  q;
    axw(`PSDI_A_ST_IDX, {24'h0, i});
    sw_wait(s);
    axr(`PSDI_A_ST_DATA, v, q);
  endtask
  task automatic req(input logic [15:0] s, input logic [19:0] p, input logic t, c, y);
    i_ep.send(s, p, t);
    chk({9'h0, rsp_code, rsp_sync, rsp_type, rsp_pasid}, {9'h0, c, y, t, p});
    chk({16'h0, rsp_tid}, {16'h0, s});
  endtask
  task automatic t_regs;
    logic [31:0] ctab [4] = '{32'h0000_1003, 32'h0000_0001, 32'h0000_0007, 32'h0000_0002};
    axr(`PSDI_A_CAP, d, r);
    chk(d, `PSDI_CAP_VAL);
    axr(8'h24, d, r);
    chk({30'h0, r}, {30'h0, `PSDI_SLVERR});
    for (int i = 0; i < 4; i++)
    begin
      axw(`PSDI_A_CTX_IDX, 32'(i));
      axw(`PSDI_A_CTX_DATA, ctab[i]);
    end
    axw(`PSDI_A_ST_IDX, 32'h13);
    axw(`PSDI_A_ST_DATA, 32'h8000_0005);
    axw(`PSDI_A_ST_IDX, 32'h2f);
    axw(`PSDI_A_ST_DATA, 32'h0);
    chk({30'h0, bresp}, {30'h0, `PSDI_OKAY});
    axw(8'h24, 32'h0);
    chk({30'h0, bresp}, {30'h0, `PSDI_SLVERR});
    axw(`PSDI_A_CTRL, 32'h0);
    axr(`PSDI_A_CTRL, d, r);
    chk(d, 32'h0);
    chk({31'h0, req_ready}, 32'h0);
    axw(`PSDI_A_CTRL, 32'h1);
  endtask
  task automatic t_sync;
    i_ep.dly = 6;
    req(16'h0, 20'h3, 1'b1, 1'b0, 1'b1);
    chk(32'(i_ep.n_inv), 32'h1);
    chk(32'(i_ep.n_flush), 32'h1);
    chk({12'h0, i_ep.last_p}, 32'h3);
    chk({31'h0, i_ep.early}, 32'h0);
    rd_st(8'h13, d);
    chk(d, 32'h0000_0006);
    i_ep.dly = 0;
    req(16'h0, 20'h3, 1'b1, 1'b0, 1'b0);
    axw(`PSDI_A_ST_DATA, 32'h8000_0007);
    req(16'h0, 20'h3, 1'b0, 1'b0, 1'b0);
    rd_st(8'h13, d);
    chk(d, 32'h8000_0006);
    req(16'h0, 20'h1f, 1'b0, 1'b0, 1'b0);
    rd_st(8'h2f, d);
    chk(d, 32'h0000_ffff);
    chk(32'(i_ep.n_inv), 32'h1);
  endtask
  task automatic t_err;
    logic [15:0] es [5] = '{16'h1, 16'h3, 16'h2, 16'h0, 16'h10};
    logic [19:0] ep [5] = '{20'h3, 20'h3, 20'h3, 20'h20, 20'h3};
    for (int i = 0; i < 5; i++)
      req(es[i], ep[i], 1'b1, 1'b1, 1'b0);
    rd_st(8'h13, d);
    chk(d, 32'h8000_0006);
    axr(`PSDI_A_STATUS, d, r);
    chk({16'h0, d[31:16]}, 32'h5);
    chk(32'(i_ep.n_kill), 32'h5);
  endtask
  task automatic t_xchg;
    rd_st(8'h2f, d);
    axw(`PSDI_A_ST_CMP, 32'h0000_0001);
    axw(`PSDI_A_ST_XCHG, 32'h8000_ffff);
    sw_wait(d);
    chk({31'h0, d[2]}, 32'h0);
    axr(`PSDI_A_ST_DATA, d, r);
    chk(d, 32'h0000_ffff);
    axw(`PSDI_A_ST_CMP, 32'h0000_ffff);
    axw(`PSDI_A_ST_XCHG, 32'h8000_ffff);
    sw_wait(d);
    chk({31'h0, d[2]}, 32'h1);
    rd_st(8'h2f, d);
    chk(d, 32'h8000_ffff);
    req(16'h0, 20'h1f, 1'b1, 1'b0, 1'b1);
    chk(32'(i_ep.n_inv), 32'h2);
    chk({12'h0, i_ep.last_p}, 32'h1f);
    chk(32'(i_ep.n_flush), 32'h2);
  endtask
  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #(20 * 20000);
    n_errors++;
    final_report;
  end
  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_sync;
    t_err;
    t_xchg;
    final_report;
  end
endmodule // psdi_core_tb_top
